//--- src/ct_pkg.sv
// Package of constants and types for the 16-bit capture timer.
package ct_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index).
    // ****************************************************************
    localparam logic [9:0] CT_IDX_RUN = 10'h180;
    localparam logic [9:0] CT_IDX_MODE = 10'h182;
    localparam logic [9:0] CT_IDX_FFCR = 10'h183;
    localparam logic [9:0] CT_IDX_CMP0L = 10'h188;
    localparam logic [9:0] CT_IDX_CMP0H = 10'h189;
    localparam logic [9:0] CT_IDX_CMP1L = 10'h18a;
    localparam logic [9:0] CT_IDX_CMP1H = 10'h18b;
    localparam logic [9:0] CT_IDX_CAP0L = 10'h18c;
    localparam logic [9:0] CT_IDX_CAP0H = 10'h18d;
    localparam logic [9:0] CT_IDX_CAP1L = 10'h18e;
    localparam logic [9:0] CT_IDX_CAP1H = 10'h18f;
    localparam logic [9:0] CT_IDX_STAT = 10'h190;
    localparam logic [9:0] CT_IDX_MASK = 10'h191;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int CT_RUN_DBUF = 7;
    localparam int CT_RUN_IDLE = 3;
    localparam int CT_RUN_PRUN = 2;
    localparam logic [7:0] CT_RUN_MASK = 8'hcd;
    localparam int CT_MODE_SWCAP = 5;
    localparam int CT_MODE_CLE = 2;
    localparam logic [7:0] CT_MODE_RST = 8'h20;
    localparam logic [7:0] CT_FFCR_RST = 8'hc0;
    localparam logic [1:0] CT_FF_INV = 2'h0;
    localparam logic [1:0] CT_FF_SET = 2'h1;
    localparam logic [1:0] CT_FF_CLR = 2'h2;
    localparam logic [1:0] CT_CLK_PIN = 2'h0;
    localparam logic [1:0] CT_CLK_T1 = 2'h1;
    localparam logic [1:0] CT_CLK_T4 = 2'h2;
    localparam logic [1:0] CT_CAP_OFF = 2'h0;
    localparam logic [1:0] CT_CAP_BOTH = 2'h1;
    localparam logic [1:0] CT_CAP_FIRST = 2'h2;
    localparam logic [3:0] CT_PRE_T4 = 4'h3;
    localparam logic [3:0] CT_PRE_T16 = 4'hf;
    // Status bits: match0, match1, capture0, capture1.
    localparam int CT_EV_W = 4;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef enum logic [1:0] {
        CT_BUS_IDLE = 2'h0,
        CT_BUS_WRITE = 2'h1,
        CT_BUS_READ = 2'h3
    } ct_bus_st_t;

    typedef struct packed {
        logic event_pin;
        logic capture_input_first;
        logic capture_input_second;
        logic eight_bit_timer_output;
    } ct_pins_t;

    typedef struct packed {
        ct_bus_st_t bus;
        logic [9:0] idx;
        logic hready;
        logic [31:0] hrdata;
        logic [7:0] run_reg;
        logic [7:0] mode_reg;
        logic [3:0] ff_trig;
        logic [15:0] cmp0;
        logic [15:0] cmp1;
        logic [15:0] buf0;
        logic [15:0] buf1;
        logic [15:0] cap0;
        logic [15:0] cap1;
        logic [15:0] cnt;
        logic half;
        logic [3:0] pre;
        ct_pins_t pin_q;
        logic ff0;
        logic ff1;
        logic [CT_EV_W-1:0] stat;
        logic [CT_EV_W-1:0] mask;
        logic irq;
    } ct_state_t;

endpackage : ct_pkg

//--- src/ct_capture_timer.sv
// 16-bit capture timer with compare flip-flops behind an AHB-Lite slave.
`timescale 1ns/1ps

// Overview of operation
// - Run bit low clears counter; high counts.
// - Idle bit chooses stop or run in idle.
// - Double buffer routes compare writes; bits 5, 4, 1 zero.
// - Clock select: pin, tap 1, 4, 16.
// - Capture timing selects edge capture sources.
// - Flip-flop control: invert, set, clear, keep.
// - Trigger bits gate event toggling of flip-flop zero; mode bits 7, 6 gate flip-flop one.
// - Capture registers read-only, hold latched count.
// - State clock is half the input clock.
// - Unimplemented bits read zero; write-only FFCR bits read one.
module ct_capture_timer
    import ct_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer pins and chip mode.
    input wire ct_pins_t pins,
    input wire logic light_idle_mode,
    output logic timer_flipflop_zero,
    output logic timer_flipflop_one,
    output logic irq
);

    // ****************************************************************
    // State and combinational helpers.
    // ****************************************************************
    ct_state_t s_ff;
    ct_state_t nxt_s;
    logic state_tick;
    logic tap4;
    logic tap16;
    logic count_tick;
    logic match0;
    logic match1;
    logic clr_match;
    logic cap0_ev;
    logic cap1_ev;
    logic idle_stop;
    logic accept;
    logic wr_en;
    logic [7:0] wd;
    logic [CT_EV_W-1:0] ev;
    logic [15:0] cnt_next;

    // Size is ignored: only whole-word transfers are expected.
    logic unused_hsize;
    assign unused_hsize = ^hsize;

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    always_comb begin
        nxt_s = s_ff;
        accept = hsel & htrans[1] & hready;
        wr_en = (s_ff.bus == CT_BUS_WRITE);
        wd = hwdata[7:0];

        // Prescaler taps hang off the halved clock so each tap is a pulse.
        state_tick = s_ff.half;
        nxt_s.half = ~s_ff.half;
        tap4 = state_tick & (s_ff.pre[1:0] == CT_PRE_T4[1:0]);
        tap16 = state_tick & (s_ff.pre == CT_PRE_T16);
        idle_stop = light_idle_mode & ~s_ff.run_reg[CT_RUN_IDLE];

        case (s_ff.mode_reg[1:0])
            CT_CLK_PIN: count_tick = pins.event_pin & ~s_ff.pin_q.event_pin;
            CT_CLK_T1: count_tick = state_tick;
            CT_CLK_T4: count_tick = tap4;
            default: count_tick = tap16;
        endcase
        count_tick = count_tick & s_ff.run_reg[CT_RUN_PRUN] & ~idle_stop;

        match0 = count_tick & (s_ff.cnt == s_ff.cmp0);
        match1 = count_tick & (s_ff.cnt == s_ff.cmp1);
        clr_match = match1 & s_ff.mode_reg[CT_MODE_CLE];
        cnt_next = s_ff.cnt + 16'h0001;

        if (!s_ff.run_reg[CT_RUN_PRUN]) begin
            nxt_s.cnt = 16'h0000;
            nxt_s.pre = 4'h0;
        end else if (!idle_stop) begin
            if (state_tick) begin
                nxt_s.pre = s_ff.pre + 4'h1;
            end
            if (clr_match) begin
                nxt_s.cnt = 16'h0000;
            end else if (count_tick) begin
                nxt_s.cnt = cnt_next;
            end
        end

        // Edge capture sources.
        case (s_ff.mode_reg[4:3])
            CT_CAP_OFF: begin
                cap0_ev = 1'b0;
                cap1_ev = 1'b0;
            end
            CT_CAP_BOTH: begin
                cap0_ev = pins.capture_input_first & ~s_ff.pin_q.capture_input_first;
                cap1_ev = pins.capture_input_second & ~s_ff.pin_q.capture_input_second;
            end
            CT_CAP_FIRST: begin
                cap0_ev = pins.capture_input_first & ~s_ff.pin_q.capture_input_first;
                cap1_ev = ~pins.capture_input_first & s_ff.pin_q.capture_input_first;
            end
            default: begin
                cap0_ev = pins.eight_bit_timer_output & ~s_ff.pin_q.eight_bit_timer_output;
                cap1_ev = ~pins.eight_bit_timer_output & s_ff.pin_q.eight_bit_timer_output;
            end
        endcase
        // A software capture rides on the capture0 path.
        if (wr_en && s_ff.idx == CT_IDX_MODE && !wd[CT_MODE_SWCAP]) begin
            cap0_ev = 1'b1;
        end
        nxt_s.pin_q = pins;
        if (cap0_ev) begin
            nxt_s.cap0 = s_ff.cnt;
        end
        if (cap1_ev) begin
            nxt_s.cap1 = s_ff.cnt;
        end

        // Double-buffered compares load when the counter wraps on compare1.
        if (clr_match && s_ff.run_reg[CT_RUN_DBUF]) begin
            nxt_s.cmp0 = s_ff.buf0;
            nxt_s.cmp1 = s_ff.buf1;
        end

        // Event toggling of the flip-flops.
        if ((s_ff.ff_trig[0] & match0) ^ (s_ff.ff_trig[1] & match1)
            ^ (s_ff.ff_trig[2] & cap0_ev) ^ (s_ff.ff_trig[3] & cap1_ev)) begin
            nxt_s.ff0 = ~s_ff.ff0;
        end
        if ((s_ff.mode_reg[6] & match1) ^ (s_ff.mode_reg[7] & cap1_ev)) begin
            nxt_s.ff1 = ~s_ff.ff1;
        end

        // Register writes in the data phase.
        ev = {cap1_ev, cap0_ev, match1, match0};
        if (wr_en) begin
            case (s_ff.idx)
                CT_IDX_RUN: nxt_s.run_reg = wd & CT_RUN_MASK;
                CT_IDX_MODE: nxt_s.mode_reg = {wd[7:6], 1'b1, wd[4:0]};
                CT_IDX_FFCR: begin
                    nxt_s.ff_trig = wd[5:2];
                    case (wd[1:0])
                        CT_FF_INV: nxt_s.ff0 = ~s_ff.ff0;
                        CT_FF_SET: nxt_s.ff0 = 1'b1;
                        CT_FF_CLR: nxt_s.ff0 = 1'b0;
                        default: nxt_s.ff0 = nxt_s.ff0;
                    endcase
                    case (wd[7:6])
                        CT_FF_INV: nxt_s.ff1 = ~s_ff.ff1;
                        CT_FF_SET: nxt_s.ff1 = 1'b1;
                        CT_FF_CLR: nxt_s.ff1 = 1'b0;
                        default: nxt_s.ff1 = nxt_s.ff1;
                    endcase
                end
                CT_IDX_CMP0L: begin
                    nxt_s.buf0[7:0] = wd;
                    if (!s_ff.run_reg[CT_RUN_DBUF]) begin
                        nxt_s.cmp0[7:0] = wd;
                    end
                end
                CT_IDX_CMP0H: begin
                    nxt_s.buf0[15:8] = wd;
                    if (!s_ff.run_reg[CT_RUN_DBUF]) begin
                        nxt_s.cmp0[15:8] = wd;
                    end
                end
                CT_IDX_CMP1L: begin
                    nxt_s.buf1[7:0] = wd;
                    if (!s_ff.run_reg[CT_RUN_DBUF]) begin
                        nxt_s.cmp1[7:0] = wd;
                    end
                end
                CT_IDX_CMP1H: begin
                    nxt_s.buf1[15:8] = wd;
                    if (!s_ff.run_reg[CT_RUN_DBUF]) begin
                        nxt_s.cmp1[15:8] = wd;
                    end
                end
                CT_IDX_MASK: nxt_s.mask = wd[CT_EV_W-1:0];
                default: nxt_s.mask = nxt_s.mask;
            endcase
        end
        // Set wins over the write-one clear so no event is lost.
        if (wr_en && s_ff.idx == CT_IDX_STAT) begin
            nxt_s.stat = (s_ff.stat & ~wd[CT_EV_W-1:0]) | ev;
        end else begin
            nxt_s.stat = s_ff.stat | ev;
        end
        nxt_s.irq = |(nxt_s.stat & nxt_s.mask);

        // Bus sequencing: reads take one wait state so a preceding write lands first.
        case (s_ff.bus)
            CT_BUS_READ: begin
                nxt_s.hready = 1'b1;
                nxt_s.bus = CT_BUS_IDLE;
                case (s_ff.idx)
                    CT_IDX_RUN: nxt_s.hrdata = {24'h000000, s_ff.run_reg};
                    CT_IDX_MODE: nxt_s.hrdata = {24'h000000, s_ff.mode_reg};
                    CT_IDX_FFCR: nxt_s.hrdata = {24'h000000, 2'h3, s_ff.ff_trig, 2'h3};
                    CT_IDX_CAP0L: nxt_s.hrdata = {24'h000000, s_ff.cap0[7:0]};
                    CT_IDX_CAP0H: nxt_s.hrdata = {24'h000000, s_ff.cap0[15:8]};
                    CT_IDX_CAP1L: nxt_s.hrdata = {24'h000000, s_ff.cap1[7:0]};
                    CT_IDX_CAP1H: nxt_s.hrdata = {24'h000000, s_ff.cap1[15:8]};
                    CT_IDX_STAT: nxt_s.hrdata = {28'h0000000, s_ff.stat};
                    CT_IDX_MASK: nxt_s.hrdata = {28'h0000000, s_ff.mask};
                    default: nxt_s.hrdata = 32'h00000000;
                endcase
            end
            default: begin
                if (accept) begin
                    nxt_s.idx = haddr[11:2];
                    nxt_s.bus = hwrite ? CT_BUS_WRITE : CT_BUS_READ;
                    nxt_s.hready = hwrite;
                end else begin
                    nxt_s.bus = CT_BUS_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.bus <= CT_BUS_IDLE;
            s_ff.hready <= 1'b1;
            s_ff.mode_reg <= CT_MODE_RST;
            s_ff.ff_trig <= CT_FFCR_RST[5:2];
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hreadyout = s_ff.hready;
    assign hresp = 1'b0;
    assign hrdata = s_ff.hrdata;
    assign timer_flipflop_zero = s_ff.ff0;
    assign timer_flipflop_one = s_ff.ff1;
    assign irq = s_ff.irq;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    stop_clear_a: assert property (
        !s_ff.run_reg[CT_RUN_PRUN] |=> s_ff.cnt == 16'h0000)
        else $error("counter not cleared while stopped");

    count_step_a: assert property (
        count_tick && !clr_match |=> s_ff.cnt == $past(s_ff.cnt) + 16'h0001)
        else $error("counter did not step by one");

    idle_hold_a: assert property (
        s_ff.run_reg[CT_RUN_PRUN] && idle_stop |=> s_ff.cnt == $past(s_ff.cnt))
        else $error("counter moved in idle stop");

    direct_cmp_a: assert property (
        wr_en && s_ff.idx == CT_IDX_CMP0L && !s_ff.run_reg[CT_RUN_DBUF]
        |=> s_ff.cmp0[7:0] == $past(hwdata[7:0]))
        else $error("direct compare write lost");

    tap16_gap_a: assert property (
        tap16 |-> ##1 !tap16 [*8])
        else $error("tap16 pulses too close");

    cap_latch_a: assert property (
        cap0_ev |=> s_ff.cap0 == $past(s_ff.cnt))
        else $error("capture0 missed counter value");

    ff_set_a: assert property (
        wr_en && s_ff.idx == CT_IDX_FFCR && hwdata[1:0] == CT_FF_SET
        |=> timer_flipflop_zero)
        else $error("flip-flop zero not set");

    trig_gate_a: assert property (
        s_ff.ff_trig == 4'h0 && !wr_en |=> $stable(timer_flipflop_zero))
        else $error("flip-flop zero toggled while gated");

    match_clear_a: assert property (
        clr_match |=> s_ff.cnt == 16'h0000)
        else $error("counter not cleared on compare1 match");

    half_clock_a: assert property (
        state_tick |=> !state_tick ##1 state_tick)
        else $error("state clock not half rate");

    read_wait_a: assert property (
        accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read did not take one wait state");

    ff_clear_a: assert property (
        wr_en && s_ff.idx == CT_IDX_FFCR && hwdata[1:0] == CT_FF_CLR
        |=> !timer_flipflop_zero)
        else $error("flip-flop zero not cleared");

    ff1_gate_a: assert property (
        s_ff.mode_reg[7:6] == 2'h0 && !(wr_en && s_ff.idx == CT_IDX_FFCR)
        |=> $stable(timer_flipflop_one))
        else $error("flip-flop one toggled while gated");

    cap_off_a: assert property (
        s_ff.mode_reg[4:3] == CT_CAP_OFF |=> $stable(s_ff.cap1))
        else $error("capture1 moved with capture off");

    buf_load_a: assert property (
        clr_match && s_ff.run_reg[CT_RUN_DBUF] |=> s_ff.cmp1 == $past(s_ff.buf1))
        else $error("buffered compare not loaded");

    soft_cap_a: assert property (
        wr_en && s_ff.idx == CT_IDX_MODE && !hwdata[CT_MODE_SWCAP]
        |=> s_ff.cap0 == $past(s_ff.cnt))
        else $error("software capture missed counter value");

    cap_cov_c: cover property (cap1_ev);
    clear_cov_c: cover property (clr_match ##1 count_tick);
    irq_cov_c: cover property ($rose(irq));
    swcap_cov_c: cover property (wr_en && s_ff.idx == CT_IDX_MODE && !hwdata[CT_MODE_SWCAP]);
    dbuf_cov_c: cover property (clr_match && s_ff.run_reg[CT_RUN_DBUF]);

endmodule : ct_capture_timer

//--- tb/ct_pin_model.sv
// Model of the capture, event and timer-output pins that face the timer.
`timescale 1ns/1ps
module ct_pin_model
    import ct_pkg::*;
(
    // Clock.
    input wire logic hclk,
    // Pins towards the timer.
    output ct_pins_t pins
);
    // ****************************************
    // Pin pulses.
    // ****************************************
    // Pins rest low between pulses.
    initial begin
        pins = '0;
    end

    // Levels are held four cycles so a half-rate state clock still sees them.
    task automatic pulse(input int b);
        @(posedge hclk);
        pins[b] <= 1'b1;
        repeat (4) @(posedge hclk);
        pins[b] <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : pulse
endmodule : ct_pin_model

//--- tb/testbench.sv
// Self-checking testbench of the 16-bit capture timer.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module testbench;
    import ct_pkg::*;
    // ****************************************
    // Signals and instances.
    // ****************************************
    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic light_idle_mode;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    ct_pins_t pins;
    logic timer_flipflop_zero;
    logic timer_flipflop_one;
    logic irq;
    logic [7:0] rv;
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    ct_capture_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pins(pins), .light_idle_mode(light_idle_mode),
        .timer_flipflop_zero(timer_flipflop_zero), .timer_flipflop_one(timer_flipflop_one),
        .irq(irq));
    ct_pin_model pm_u (.hclk(hclk), .pins(pins));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // A hung handshake would otherwise stall the run forever.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // ****************************************
    // Bus tasks.
    // ****************************************
    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {20'h0, i, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata[7:0];
    endtask : bus

    task automatic chk_rd(input logic [9:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h0);
        `CHK("register", e, rv)
    endtask : chk_rd

    task automatic rd16(input logic [9:0] i, output logic [15:0] v);
        bus(1'b0, i, 8'h0);
        v[7:0] = rv;
        bus(1'b0, i + 10'h1, 8'h0);
        v[15:8] = rv;
    endtask : rd16

    task automatic cap_sw(input logic [7:0] m, output logic [15:0] v);
        bus(1'b1, CT_IDX_MODE, m & 8'hdf);
        rd16(CT_IDX_CAP0L, v);
    endtask : cap_sw

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset();
        chk_rd(CT_IDX_RUN, 8'h00);
        chk_rd(CT_IDX_MODE, 8'h20);
        chk_rd(CT_IDX_FFCR, 8'hc3);
        chk_rd(10'h1f0, 8'h00);
        chk_rd(CT_IDX_CMP0L, 8'h00);
        bus(1'b1, CT_IDX_RUN, 8'h8d);
        chk_rd(CT_IDX_RUN, 8'h8d);
        bus(1'b1, CT_IDX_RUN, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count();
        logic [15:0] v;
        bus(1'b1, CT_IDX_RUN, 8'h04);
        repeat (5) pm_u.pulse(3);
        cap_sw(8'h00, v);
        `CHK("pin count", 16'h0005, v)
        light_idle_mode <= 1'b1;
        repeat (3) pm_u.pulse(3);
        cap_sw(8'h00, v);
        `CHK("idle stop", 16'h0005, v)
        bus(1'b1, CT_IDX_RUN, 8'h0c);
        repeat (2) pm_u.pulse(3);
        cap_sw(8'h00, v);
        `CHK("idle run", 16'h0007, v)
        light_idle_mode <= 1'b0;
        bus(1'b1, CT_IDX_RUN, 8'h00);
        cap_sw(8'h00, v);
        `CHK("stop clear", 16'h0000, v)
        $display("test count done");
    endtask : t_count

    // Mode 00 must leave both captures alone; the others capture the count.
    task automatic t_capture();
        logic [15:0] v;
        logic [15:0] e;
        bus(1'b1, CT_IDX_RUN, 8'h04);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, CT_IDX_MODE, 8'h20 | 8'(k << 3));
            pm_u.pulse(3);
            pm_u.pulse(2);
            pm_u.pulse(1);
            pm_u.pulse(0);
            e = (k == 0) ? 16'h0 : 16'(k + 1);
            rd16(CT_IDX_CAP0L, v);
            `CHK("capture0", e, v)
            rd16(CT_IDX_CAP1L, v);
            `CHK("capture1", e, v)
        end
        $display("test capture done");
    endtask : t_capture

    // The prescaler phase is unknown, so two ticks of slack below and one above are allowed.
    task automatic t_taps();
        logic [15:0] v;
        int n;
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, CT_IDX_RUN, 8'h00);
            bus(1'b1, CT_IDX_MODE, 8'h20 | 8'(s));
            bus(1'b1, CT_IDX_RUN, 8'h04);
            repeat (61) @(posedge hclk);
            cap_sw(8'(s), v);
            n = 32 >> (2 * (s - 1));
            `CHK("tap count", 1'b1, (v >= 16'(n - 2) && v <= 16'(n + 1)))
        end
        $display("test taps done");
    endtask : t_taps

    task automatic t_ff();
        logic [7:0] d [5] = '{8'h41, 8'hc3, 8'h82, 8'h00, 8'h00};
        logic [1:0] e [5] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h0};
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, CT_IDX_FFCR, d[i]);
            #1;
            `CHK("flip-flops", e[i], {timer_flipflop_one, timer_flipflop_zero})
        end
        $display("test flip-flop done");
    endtask : t_ff

    task automatic t_match();
        logic [15:0] v;
        bus(1'b1, CT_IDX_RUN, 8'h00);
        bus(1'b1, CT_IDX_FFCR, 8'hc7);
        bus(1'b1, CT_IDX_CMP0L, 8'h03);
        bus(1'b1, CT_IDX_CMP0H, 8'h00);
        bus(1'b1, CT_IDX_MODE, 8'h20);
        bus(1'b1, CT_IDX_RUN, 8'h04);
        repeat (4) pm_u.pulse(3);
        #1;
        `CHK("match toggle", 1'b1, timer_flipflop_zero)
        bus(1'b1, CT_IDX_FFCR, 8'hc3);
        bus(1'b1, CT_IDX_RUN, 8'h00);
        bus(1'b1, CT_IDX_RUN, 8'h04);
        repeat (4) pm_u.pulse(3);
        #1;
        `CHK("gated toggle", 1'b1, timer_flipflop_zero)
        bus(1'b1, CT_IDX_CMP1L, 8'h03);
        bus(1'b1, CT_IDX_CMP1H, 8'h00);
        bus(1'b1, CT_IDX_MODE, 8'h64);
        bus(1'b1, CT_IDX_RUN, 8'h00);
        bus(1'b1, CT_IDX_RUN, 8'h04);
        repeat (4) pm_u.pulse(3);
        cap_sw(8'h04, v);
        `CHK("match clear", 16'h0000, v)
        #1;
        `CHK("irq masked", 1'b0, irq)
        `CHK("ff1 toggle", 1'b1, timer_flipflop_one)
        bus(1'b1, CT_IDX_MASK, 8'h04);
        @(posedge hclk);
        #1;
        `CHK("irq raised", 1'b1, irq)
        bus(1'b1, CT_IDX_STAT, 8'h04);
        @(posedge hclk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
        bus(1'b1, CT_IDX_RUN, 8'h84);
        bus(1'b1, CT_IDX_CMP1L, 8'h05);
        bus(1'b1, CT_IDX_CMP1H, 8'h00);
        repeat (4) pm_u.pulse(3);
        cap_sw(8'h04, v);
        `CHK("buffered compare", 16'h0000, v)
        repeat (6) pm_u.pulse(3);
        cap_sw(8'h04, v);
        `CHK("loaded compare", 16'h0000, v)
        $display("test match done");
    endtask : t_match

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        light_idle_mode = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_count();
        t_capture();
        t_taps();
        t_ff();
        t_match();
        conclude();
    end
endmodule : testbench
